/* File: include/prs_pkg.sv */
// package: constants, register map and types of the port read-data selector
package prs_pkg;
	localparam int NUM_PORTS = 5;
	localparam int ADDR_W = 18;
	localparam int DATA_W = 32;
	localparam int PORT_W = 8;
	// register byte addresses
	localparam logic [17:0] CTRL_ADDR = 18'h00000;
	localparam logic [17:0] DIR_BASE = 18'h00010;
	localparam logic [17:0] DATA_BASE = 18'h00030;
	localparam logic [17:0] PORT_STRIDE = 18'h00004;
	localparam logic [15:0] MODE_STATUS_INDEX = 16'hff12;
	localparam logic [17:0] MODE_STATUS_ADDR = {MODE_STATUS_INDEX, 2'b00};
	// control register fields
	localparam int CTRL_W = 5;
	localparam int BUS_RELEASE_BIT = 0;
	localparam int PIN_WAIT_BIT = 1;
	localparam int INT0_EN_BIT = 2;
	localparam int INT1_EN_BIT = 3;
	localparam int TRIG_EN_BIT = 4;
	// reset values
	localparam logic [4:0] CTRL_RESET = 5'h00;
	localparam logic [7:0] DIR_RESET = 8'h00;
	localparam logic [7:0] LATCH_RESET = 8'h00;
	localparam logic [2:0] MODE_RESET = 3'h0;
	localparam logic [7:0] MODE_RSVD_READ = 8'hc0;
	localparam logic [7:0] ALL_ONES = 8'hff;
	// cycles after reset release before the mode pins are captured
	localparam logic [1:0] MODE_SETTLE_CYCLES = 2'h2;
	// operating modes
	localparam logic [2:0] MODE_1 = 3'h1;
	localparam logic [2:0] MODE_2 = 3'h2;
	localparam logic [2:0] MODE_3 = 3'h3;
	localparam logic [2:0] MODE_4 = 3'h4;
	localparam logic [2:0] MODE_7 = 3'h7;
	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {
		S_IDLE,
		S_WAIT,
		S_BRESP,
		S_RRESP
	} prs_axs_state_t;
endpackage

/* File: include/prs_regbus_if.sv */
// interface: register access strobes between the bus slave and the register file
`timescale 1ns/100ps
interface prs_regbus_if;
	logic wr_req;
	logic rd_req;
	logic [17:0] addr;
	logic [31:0] wdata;
	logic [3:0] wstrb;
	logic ack;
	logic err;
	logic [31:0] rd_data;
	modport slave_end (output wr_req, output rd_req, output addr, output wdata, output wstrb,
		input ack, input err, input rd_data);
	modport regs_end (input wr_req, input rd_req, input addr, input wdata, input wstrb,
		output ack, output err, output rd_data);
endinterface

/* File: rtl/prs_axil_slave.sv */
// module: axi4-lite slave front end issuing one register access at a time
`timescale 1ns/100ps
module prs_axil_slave (
	// clock, reset, enable
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// write address and data
	input wire logic [17:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// read
	input wire logic [17:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// register side
	prs_regbus_if.slave_end bus
);
	prs_pkg::prs_axs_state_t state_reg;
	logic [17:0] waddr_reg;
	logic [17:0] raddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic is_write_reg;

	////////////////////////////////////////////////////////////////////////
	// channel capture, each ready drops while its item is held
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			waddr_reg <= '0;
		end else if (ce) begin
			if (awvalid && awready) begin
				awready <= 1'b0;
				waddr_reg <= awaddr;
			end else if (state_reg == prs_pkg::S_BRESP && bready) begin
				awready <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wready <= 1'b1;
			wdata_reg <= '0;
			wstrb_reg <= '0;
		end else if (ce) begin
			if (wvalid && wready) begin
				wready <= 1'b0;
				wdata_reg <= wdata;
				wstrb_reg <= wstrb;
			end else if (state_reg == prs_pkg::S_BRESP && bready) begin
				wready <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			raddr_reg <= '0;
		end else if (ce) begin
			if (arvalid && arready) begin
				arready <= 1'b0;
				raddr_reg <= araddr;
			end else if (state_reg == prs_pkg::S_RRESP && rready) begin
				arready <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// access sequencer, writes before reads
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= prs_pkg::S_IDLE;
			bus.wr_req <= 1'b0;
			bus.rd_req <= 1'b0;
			bus.addr <= '0;
			bus.wdata <= '0;
			bus.wstrb <= '0;
			is_write_reg <= 1'b0;
			bvalid <= 1'b0;
			bresp <= prs_pkg::RESP_OKAY;
			rvalid <= 1'b0;
			rresp <= prs_pkg::RESP_OKAY;
			rdata <= '0;
		end else if (ce) begin
			case (state_reg)
				prs_pkg::S_IDLE: begin
					if (!awready && !wready) begin
						bus.wr_req <= 1'b1;
						bus.addr <= waddr_reg;
						bus.wdata <= wdata_reg;
						bus.wstrb <= wstrb_reg;
						is_write_reg <= 1'b1;
						state_reg <= prs_pkg::S_WAIT;
					end else if (!arready) begin
						bus.rd_req <= 1'b1;
						bus.addr <= raddr_reg;
						is_write_reg <= 1'b0;
						state_reg <= prs_pkg::S_WAIT;
					end
				end
				prs_pkg::S_WAIT: begin
					bus.wr_req <= 1'b0;
					bus.rd_req <= 1'b0;
					if (bus.ack && is_write_reg) begin
						bvalid <= 1'b1;
						bresp <= bus.err ? prs_pkg::RESP_SLVERR : prs_pkg::RESP_OKAY;
						state_reg <= prs_pkg::S_BRESP;
					end else if (bus.ack) begin
						rvalid <= 1'b1;
						rdata <= bus.rd_data;
						rresp <= bus.err ? prs_pkg::RESP_SLVERR : prs_pkg::RESP_OKAY;
						state_reg <= prs_pkg::S_RRESP;
					end
				end
				prs_pkg::S_BRESP: begin
					if (bready) begin
						bvalid <= 1'b0;
						state_reg <= prs_pkg::S_IDLE;
					end
				end
				prs_pkg::S_RRESP: begin
					if (rready) begin
						rvalid <= 1'b0;
						state_reg <= prs_pkg::S_IDLE;
					end
				end
				default: begin
					state_reg <= prs_pkg::S_IDLE;
				end
			endcase
		end
	end
endmodule

/* File: rtl/prs_port_read.sv */
// module: port 1 to 5 latches, direction bits, mode capture and read-data selection
`timescale 1ns/100ps
// Summary of operation
// - port 1 bit 0 reads pin when input, system clock when output
// - port 1 bit 1 reads pin when input, E clock when output
// - port 1 bit 2 reads latch in modes 1-4 with bus release on, else direction
// - port 1 bit 3 direction selects pin or latch without bus release, or mode 7
// - port 1 bit 4 direction selects pin or latch without pin wait, or mode 7
// - port 1 bit 5 reads pin while interrupt 0 enabled, else direction
// - port 1 bit 6 reads pin while trigger or interrupt 1 enabled, else direction
// - port 1 bit 7 reads timer output while enabled, else direction
// - port 2 reads latch in modes 1-4, direction selects in mode 7
// - port 3 reads all ones in modes 1-4, direction selects in mode 7
// - port 4 reads latch in modes 1-4, direction selects in mode 7
// - port 5 reads latch in modes 1 and 3, direction selects in 2, 4, 7
// - mode pins captured after reset into read-only mode status bits
module prs_port_read (
	// clock, reset, enable
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// axi4-lite
	input wire logic [17:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [17:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// port pins, index 0 is port 1
	input wire logic [4:0][7:0] pin_in,
	output logic [4:0][7:0] pin_out,
	output logic [4:0][7:0] pin_oe,
	// mode pins
	input wire logic mode_pin2,
	input wire logic mode_pin1,
	input wire logic mode_pin0,
	// on-chip sources
	input wire logic sys_clk_level,
	input wire logic e_clk_level,
	input wire logic timer8_out_value,
	input wire logic timer8_out_enable,
	// status
	output logic [2:0] operating_mode
);
	prs_regbus_if bus ();
	logic [4:0][7:0] pin_meta_reg;
	logic [4:0][7:0] pin_sync_reg;
	logic [2:0] mode_meta_reg;
	logic [2:0] mode_sync_reg;
	logic [1:0] settle_cnt_reg;
	logic mode_valid_reg;
	logic [2:0] mode_reg;
	logic [4:0] ctrl_reg;
	logic [4:0][7:0] dir_reg;
	logic [4:0][7:0] latch_reg;
	logic ack_reg;
	logic err_reg;
	logic [31:0] rd_data_reg;
	logic exp_mode;
	logic [4:0][7:0] dflt_sel;
	logic [4:0][7:0] read_sel;
	logic ctrl_hit;
	logic mode_hit;
	logic dir_hit;
	logic data_hit;
	logic [2:0] port_idx;
	logic rd_go;
	logic wr_go;
	logic p1_read;

	prs_axil_slave u_slave (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.awaddr(awaddr),
		.awvalid(awvalid),
		.awready(awready),
		.wdata(wdata),
		.wstrb(wstrb),
		.wvalid(wvalid),
		.wready(wready),
		.bresp(bresp),
		.bvalid(bvalid),
		.bready(bready),
		.araddr(araddr),
		.arvalid(arvalid),
		.arready(arready),
		.rdata(rdata),
		.rresp(rresp),
		.rvalid(rvalid),
		.rready(rready),
		.bus(bus)
	);

	assign pin_out = latch_reg;
	assign pin_oe = dir_reg;
	assign operating_mode = mode_reg;
	assign bus.ack = ack_reg;
	assign bus.err = err_reg;
	assign bus.rd_data = rd_data_reg;
	assign rd_go = ce && bus.rd_req;
	assign wr_go = ce && bus.wr_req;
	assign p1_read = rd_go && data_hit && (port_idx == 3'h0);

	////////////////////////////////////////////////////////////////////////
	// pin and mode pin synchronisers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_meta_reg <= '0;
			pin_sync_reg <= '0;
			mode_meta_reg <= '0;
			mode_sync_reg <= '0;
		end else if (ce) begin
			pin_meta_reg <= pin_in;
			pin_sync_reg <= pin_meta_reg;
			mode_meta_reg <= {mode_pin2, mode_pin1, mode_pin0};
			mode_sync_reg <= mode_meta_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// mode capture once the synchroniser has filled after reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			settle_cnt_reg <= '0;
			mode_valid_reg <= 1'b0;
			mode_reg <= prs_pkg::MODE_RESET;
		end else if (ce && !mode_valid_reg) begin
			if (settle_cnt_reg == prs_pkg::MODE_SETTLE_CYCLES) begin
				mode_valid_reg <= 1'b1;
				mode_reg <= mode_sync_reg;
			end else begin
				settle_cnt_reg <= settle_cnt_reg + 2'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// address decode
	always_comb begin
		ctrl_hit = (bus.addr == prs_pkg::CTRL_ADDR);
		mode_hit = (bus.addr == prs_pkg::MODE_STATUS_ADDR);
		dir_hit = 1'b0;
		data_hit = 1'b0;
		port_idx = 3'h0;
		for (int p = 0; p < prs_pkg::NUM_PORTS; p++) begin
			if (bus.addr == prs_pkg::DIR_BASE + prs_pkg::PORT_STRIDE * 18'(p)) begin
				dir_hit = 1'b1;
				port_idx = 3'(p);
			end
			if (bus.addr == prs_pkg::DATA_BASE + prs_pkg::PORT_STRIDE * 18'(p)) begin
				data_hit = 1'b1;
				port_idx = 3'(p);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// software writes, only byte lane 0 carries register bits
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg <= prs_pkg::CTRL_RESET;
			dir_reg <= {prs_pkg::NUM_PORTS{prs_pkg::DIR_RESET}};
			latch_reg <= {prs_pkg::NUM_PORTS{prs_pkg::LATCH_RESET}};
		end else if (wr_go && bus.wstrb[0]) begin
			if (ctrl_hit) begin
				ctrl_reg <= bus.wdata[prs_pkg::CTRL_W-1:0];
			end
			if (dir_hit) begin
				dir_reg[port_idx] <= bus.wdata[7:0];
			end
			if (data_hit) begin
				latch_reg[port_idx] <= bus.wdata[7:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// port read-data selection
	always_comb begin
		exp_mode = (mode_reg >= prs_pkg::MODE_1) && (mode_reg <= prs_pkg::MODE_4);
		for (int p = 0; p < prs_pkg::NUM_PORTS; p++) begin
			dflt_sel[p] = (dir_reg[p] & latch_reg[p]) | (~dir_reg[p] & pin_sync_reg[p]);
		end
		read_sel = dflt_sel;
		read_sel[0][0] = dir_reg[0][0] ? sys_clk_level : pin_sync_reg[0][0];
		read_sel[0][1] = dir_reg[0][1] ? e_clk_level : pin_sync_reg[0][1];
		if (exp_mode && ctrl_reg[prs_pkg::BUS_RELEASE_BIT]) begin
			read_sel[0][2] = latch_reg[0][2];
			read_sel[0][3] = pin_sync_reg[0][3];
		end
		if (exp_mode && ctrl_reg[prs_pkg::PIN_WAIT_BIT]) begin
			read_sel[0][4] = pin_sync_reg[0][4];
		end
		if (ctrl_reg[prs_pkg::INT0_EN_BIT]) begin
			read_sel[0][5] = pin_sync_reg[0][5];
		end
		if (ctrl_reg[prs_pkg::TRIG_EN_BIT] || ctrl_reg[prs_pkg::INT1_EN_BIT]) begin
			read_sel[0][6] = pin_sync_reg[0][6];
		end
		if (timer8_out_enable) begin
			read_sel[0][7] = timer8_out_value;
		end
		if (exp_mode) begin
			read_sel[1] = latch_reg[1];
			read_sel[2] = prs_pkg::ALL_ONES;
			read_sel[3] = latch_reg[3];
		end
		if (mode_reg == prs_pkg::MODE_1 || mode_reg == prs_pkg::MODE_3) begin
			read_sel[4] = latch_reg[4];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// access answer, one cycle after the request
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ack_reg <= 1'b0;
			err_reg <= 1'b0;
			rd_data_reg <= '0;
		end else if (ce) begin
			ack_reg <= bus.wr_req || bus.rd_req;
			err_reg <= !(ctrl_hit || mode_hit || dir_hit || data_hit);
			if (bus.rd_req) begin
				rd_data_reg <= '0;
				if (ctrl_hit) begin
					rd_data_reg[prs_pkg::CTRL_W-1:0] <= ctrl_reg;
				end
				if (mode_hit) begin
					rd_data_reg[7:0] <= {prs_pkg::MODE_RSVD_READ[7:3], mode_reg};
				end
				if (dir_hit) begin
					rd_data_reg[7:0] <= dir_reg[port_idx];
				end
				if (data_hit) begin
					rd_data_reg[7:0] <= read_sel[port_idx];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_p1_clock_read: assert property (
		p1_read |=> rd_data_reg[0] == ($past(dir_reg[0][0]) ? $past(sys_clk_level) : $past(pin_sync_reg[0][0])))
		else $error("port 1 bit 0 read wrong");
	chk_p1_eclk_read: assert property (
		p1_read && dir_reg[0][1] |=> rd_data_reg[1] == $past(e_clk_level))
		else $error("port 1 bit 1 read wrong");
	chk_p1_release_latch: assert property (
		p1_read && exp_mode && ctrl_reg[prs_pkg::BUS_RELEASE_BIT] |=> rd_data_reg[2] == $past(latch_reg[0][2]))
		else $error("port 1 bit 2 read wrong");
	chk_p1_release_pin: assert property (
		p1_read && exp_mode && ctrl_reg[prs_pkg::BUS_RELEASE_BIT] |=> rd_data_reg[3] == $past(pin_sync_reg[0][3]))
		else $error("port 1 bit 3 read wrong");
	chk_p1_wait_pin: assert property (
		p1_read && exp_mode && ctrl_reg[prs_pkg::PIN_WAIT_BIT] |=> rd_data_reg[4] == $past(pin_sync_reg[0][4]))
		else $error("port 1 bit 4 read wrong");
	chk_p1_int0_pin: assert property (
		p1_read && ctrl_reg[prs_pkg::INT0_EN_BIT] |=> rd_data_reg[5] == $past(pin_sync_reg[0][5]))
		else $error("port 1 bit 5 read wrong");
	chk_p1_trig_pin: assert property (
		p1_read && (ctrl_reg[prs_pkg::TRIG_EN_BIT] || ctrl_reg[prs_pkg::INT1_EN_BIT])
		|=> rd_data_reg[6] == $past(pin_sync_reg[0][6]))
		else $error("port 1 bit 6 read wrong");
	chk_p1_timer_out: assert property (
		p1_read && timer8_out_enable |=> rd_data_reg[7] == $past(timer8_out_value))
		else $error("port 1 bit 7 read wrong");
	chk_p1_bit2_dir: assert property (
		p1_read && !(exp_mode && ctrl_reg[prs_pkg::BUS_RELEASE_BIT])
		|=> rd_data_reg[2] == ($past(dir_reg[0][2]) ? $past(latch_reg[0][2]) : $past(pin_sync_reg[0][2])))
		else $error("port 1 bit 2 direction read wrong");
	chk_p1_bit3_dir: assert property (
		p1_read && !(exp_mode && ctrl_reg[prs_pkg::BUS_RELEASE_BIT])
		|=> rd_data_reg[3] == ($past(dir_reg[0][3]) ? $past(latch_reg[0][3]) : $past(pin_sync_reg[0][3])))
		else $error("port 1 bit 3 direction read wrong");
	chk_p1_bit4_dir: assert property (
		p1_read && !(exp_mode && ctrl_reg[prs_pkg::PIN_WAIT_BIT])
		|=> rd_data_reg[4] == ($past(dir_reg[0][4]) ? $past(latch_reg[0][4]) : $past(pin_sync_reg[0][4])))
		else $error("port 1 bit 4 direction read wrong");
	chk_p1_bit5_dir: assert property (
		p1_read && !ctrl_reg[prs_pkg::INT0_EN_BIT]
		|=> rd_data_reg[5] == ($past(dir_reg[0][5]) ? $past(latch_reg[0][5]) : $past(pin_sync_reg[0][5])))
		else $error("port 1 bit 5 direction read wrong");
	chk_p1_bit6_dir: assert property (
		p1_read && !ctrl_reg[prs_pkg::TRIG_EN_BIT] && !ctrl_reg[prs_pkg::INT1_EN_BIT]
		|=> rd_data_reg[6] == ($past(dir_reg[0][6]) ? $past(latch_reg[0][6]) : $past(pin_sync_reg[0][6])))
		else $error("port 1 bit 6 direction read wrong");
	chk_p1_bit7_dir: assert property (
		p1_read && !timer8_out_enable
		|=> rd_data_reg[7] == ($past(dir_reg[0][7]) ? $past(latch_reg[0][7]) : $past(pin_sync_reg[0][7])))
		else $error("port 1 bit 7 direction read wrong");
	chk_p2_exp_latch: assert property (
		rd_go && data_hit && port_idx == 3'h1 && exp_mode |=> rd_data_reg[7:0] == $past(latch_reg[1]))
		else $error("port 2 read wrong");
	chk_p3_exp_ones: assert property (
		rd_go && data_hit && port_idx == 3'h2 && exp_mode |=> rd_data_reg == 32'h000000ff)
		else $error("port 3 read wrong");
	chk_p4_single_dir: assert property (
		rd_go && data_hit && port_idx == 3'h3 && mode_reg == prs_pkg::MODE_7
		|=> rd_data_reg[7:0] == (($past(dir_reg[3]) & $past(latch_reg[3]))
			| (~$past(dir_reg[3]) & $past(pin_sync_reg[3]))))
		else $error("port 4 read wrong");
	chk_p4_exp_latch: assert property (
		rd_go && data_hit && port_idx == 3'h3 && exp_mode |=> rd_data_reg[7:0] == $past(latch_reg[3]))
		else $error("port 4 latch read wrong");
	chk_p5_mode_latch: assert property (
		rd_go && data_hit && port_idx == 3'h4 && (mode_reg == prs_pkg::MODE_1 || mode_reg == prs_pkg::MODE_3)
		|=> rd_data_reg[7:0] == $past(latch_reg[4]))
		else $error("port 5 read wrong");
	chk_p2_single_dir: assert property (
		rd_go && data_hit && port_idx == 3'h1 && mode_reg == prs_pkg::MODE_7
		|=> rd_data_reg[7:0] == (($past(dir_reg[1]) & $past(latch_reg[1]))
			| (~$past(dir_reg[1]) & $past(pin_sync_reg[1]))))
		else $error("port 2 direction read wrong");
	chk_p3_single_dir: assert property (
		rd_go && data_hit && port_idx == 3'h2 && mode_reg == prs_pkg::MODE_7
		|=> rd_data_reg[7:0] == (($past(dir_reg[2]) & $past(latch_reg[2]))
			| (~$past(dir_reg[2]) & $past(pin_sync_reg[2]))))
		else $error("port 3 direction read wrong");
	chk_p5_mode_dir: assert property (
		rd_go && data_hit && port_idx == 3'h4
		&& (mode_reg == prs_pkg::MODE_2 || mode_reg == prs_pkg::MODE_4 || mode_reg == prs_pkg::MODE_7)
		|=> rd_data_reg[7:0] == (($past(dir_reg[4]) & $past(latch_reg[4]))
			| (~$past(dir_reg[4]) & $past(pin_sync_reg[4]))))
		else $error("port 5 direction read wrong");
	chk_ce_freeze_state: assert property (
		!ce |=> $stable(mode_reg) && $stable(ctrl_reg) && $stable(dir_reg) && $stable(latch_reg))
		else $error("state changed while clock enable low");
	chk_mode_capture_hold: assert property (
		mode_valid_reg |=> $stable(mode_reg) && mode_valid_reg)
		else $error("mode status changed after capture");
	chk_mode_capture_time: assert property (
		$rose(mode_valid_reg) |-> mode_reg == $past(mode_sync_reg) && settle_cnt_reg == prs_pkg::MODE_SETTLE_CYCLES)
		else $error("mode capture wrong");

	cov_p3_exp_read: cover property (rd_go && data_hit && port_idx == 3'h2 && exp_mode);
	cov_timer_read: cover property (p1_read && timer8_out_enable);
	cov_write_then_read: cover property (wr_go && data_hit ##[1:20] rd_go && data_hit);
	cov_unmapped: cover property (rd_go && !(ctrl_hit || mode_hit || dir_hit || data_hit));
endmodule

/* File: tb/prs_pin_model.sv */
// partner model: the board-side level of every port pin
`timescale 1ns/100ps
module prs_pin_model (
	// device side
	input wire logic [4:0][7:0] pin_out,
	input wire logic [4:0][7:0] pin_oe,
	// board side
	input wire logic [4:0][7:0] ext_level,
	output logic [4:0][7:0] pin_in
);
	////////////////////////////////////////////////////////////////
	// a driven pin shows the device level, an input pin the board pattern
	// the bench renews the pattern each test so stale values never match
	always_comb begin
		for (int p = 0; p < 5; p++) begin
			pin_in[p] = (pin_oe[p] & pin_out[p]) | (~pin_oe[p] & ext_level[p]);
		end
	end
endmodule

/* File: tb/testbench.sv */
// testbench: port read-data selection through the axi4-lite registers
`timescale 1ns/100ps
module testbench;
	logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid;
	logic [17:0] awaddr = 18'h0, araddr = 18'h0;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0] wstrb = 4'hf;
	logic [1:0] bresp, rresp;
	logic [4:0][7:0] pin_in, pin_out, pin_oe, ext = '0;
	logic [2:0] mpin = 3'h0, operating_mode;
	logic sc = 1'b0, ec = 1'b0, tv = 1'b0, te = 1'b0, ce = 1'b1;
	logic [33:0] rq[$];
	logic [1:0] bq[$];
	int bad_count = 0, tests_run = 0, seed = 69209;
	always #5 aclk = ~aclk;
	////////////////////////////////////////////////////////////////
	prs_port_read dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe(pin_oe), .mode_pin2(mpin[2]), .mode_pin1(mpin[1]), .mode_pin0(mpin[0]),
		.sys_clk_level(sc), .e_clk_level(ec), .timer8_out_value(tv), .timer8_out_enable(te),
		.operating_mode(operating_mode));
	prs_pin_model pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext), .pin_in(pin_in));
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [33:0] got, input logic [33:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic complete_run;
		$display("comparisons %0d, mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// scoreboard: each handshake takes the oldest note
	always @(negedge aclk) begin
		if (rvalid && rready) begin
			if (rq.size() == 0) chk({rresp, rdata}, 34'h3ffffffff);
			else chk({rresp, rdata}, rq.pop_front());
		end
		if (bvalid && bready) begin
			if (bq.size() == 0) chk({32'h0, bresp}, 34'h3);
			else chk({32'h0, bresp}, {32'h0, bq.pop_front()});
		end
	end
	initial begin
		repeat (60000) @(posedge aclk);
		bad_count++;
		complete_run;
	end
	////////////////////////////////////////////////////////////////
	task automatic axw(input logic [17:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ah, wh, bh;
		bq.push_back(er);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge aclk);
			ah = awvalid && awready;
			wh = wvalid && wready;
			bh = bvalid;
			@(posedge aclk);
			if (ah) awvalid <= 1'b0;
			if (wh) wvalid <= 1'b0;
			if (bh) bready <= 1'b0;
		end while (!bh);
	endtask
	task automatic axr(input logic [17:0] a, input logic [33:0] exp);
		logic ah, rh;
		rq.push_back(exp);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge aclk);
			ah = arvalid && arready;
			rh = rvalid;
			@(posedge aclk);
			if (ah) arvalid <= 1'b0;
			if (rh) rready <= 1'b0;
		end while (!rh);
	endtask
	// expected port read from mode, control, direction, latch and board level
	function automatic logic [7:0] exp_rd(input int p, input logic [2:0] m, input logic [4:0] c,
		input logic [7:0] d, input logic [7:0] l, input logic [7:0] e);
		logic [7:0] pin, r;
		logic xm;
		pin = (d & l) | (~d & e);
		r = (d & l) | (~d & pin);
		xm = (m >= 3'h1) && (m <= 3'h4);
		case (p)
			0: begin
				r[0] = d[0] ? sc : pin[0];
				r[1] = d[1] ? ec : pin[1];
				if (xm && c[prs_pkg::BUS_RELEASE_BIT]) r[2] = l[2];
				if (xm && c[prs_pkg::BUS_RELEASE_BIT]) r[3] = pin[3];
				if (xm && c[prs_pkg::PIN_WAIT_BIT]) r[4] = pin[4];
				if (c[prs_pkg::INT0_EN_BIT]) r[5] = pin[5];
				if (c[prs_pkg::INT1_EN_BIT] || c[prs_pkg::TRIG_EN_BIT]) r[6] = pin[6];
				if (te) r[7] = tv;
			end
			1, 3: if (xm) r = l;
			2: if (xm) r = prs_pkg::ALL_ONES;
			default: if (m == prs_pkg::MODE_1 || m == prs_pkg::MODE_3) r = l;
		endcase
		return r;
	endfunction
	////////////////////////////////////////////////////////////////
	initial begin
		logic [4:0] c;
		logic [4:0][7:0] d, l;
		for (int m = 0; m < 8; m++) begin
			@(posedge aclk);
			mpin <= m[2:0];
			aresetn <= 1'b0;
			repeat (4) @(posedge aclk);
			aresetn <= 1'b1;
			ce <= 1'b0;
			repeat (6) @(posedge aclk);
			chk({31'h0, operating_mode}, 34'h0);
			ce <= 1'b1;
			repeat (6) @(posedge aclk);
			chk({31'h0, operating_mode}, {31'h0, m[2:0]});
			chk({2'h0, pin_out[3:0]}, 34'h0);
			chk({2'h0, pin_oe[3:0]}, 34'h0);
			chk({18'h0, pin_out[4], pin_oe[4]}, 34'h0);
			axr(prs_pkg::MODE_STATUS_ADDR, {26'h0, prs_pkg::MODE_RSVD_READ | {5'h0, m[2:0]}});
			for (int t = 0; t < 5; t++) begin
				c = 5'($random(seed));
				d = {$random(seed), 8'($random(seed))};
				l = {$random(seed), 8'($random(seed))};
				@(posedge aclk);
				ext <= {$random(seed), 8'($random(seed))};
				{sc, ec, tv, te} <= 4'($random(seed));
				axw(prs_pkg::CTRL_ADDR, {27'h0, c}, prs_pkg::RESP_OKAY);
				for (int p = 0; p < 5; p++) begin
					axw(prs_pkg::DIR_BASE + 18'(p) * prs_pkg::PORT_STRIDE, {24'h0, d[p]}, prs_pkg::RESP_OKAY);
					axw(prs_pkg::DATA_BASE + 18'(p) * prs_pkg::PORT_STRIDE, {24'h0, l[p]}, prs_pkg::RESP_OKAY);
				end
				repeat (4) @(posedge aclk);
				chk({18'h0, pin_out[4], pin_oe[4]}, {18'h0, l[4], d[4]});
				chk({2'h0, pin_out[3:0]}, {2'h0, l[3:0]});
				chk({2'h0, pin_oe[3:0]}, {2'h0, d[3:0]});
				for (int p = 0; p < 5; p++) begin
					axr(prs_pkg::DATA_BASE + 18'(p) * prs_pkg::PORT_STRIDE,
						{26'h0, exp_rd(p, m[2:0], c, d[p], l[p], ext[p])});
				end
			end
			$display("test mode %0d done", m);
		end
		// refused and read-only accesses
		axw(18'h00100, 32'h000000ff, prs_pkg::RESP_SLVERR);
		axr(18'h00100, {prs_pkg::RESP_SLVERR, 32'h0});
		axw(prs_pkg::MODE_STATUS_ADDR, 32'h00000000, prs_pkg::RESP_OKAY);
		axr(prs_pkg::MODE_STATUS_ADDR, {26'h0, prs_pkg::MODE_RSVD_READ | 8'h07});
		$display("test refused accesses done");
		repeat (4) @(posedge aclk);
		complete_run;
	end
endmodule
